/* design/eepc_pkg.sv */
package eepc_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] EEPC_IDX_PROG = 16'h103B;
  localparam logic [15:0] EEPC_IDX_SETUP = 16'h103F;
  localparam logic [15:0] EEPC_IDX_CTRL = 16'h1040;
  localparam logic [15:0] EEPC_IDX_STAT = 16'h1041;
  localparam logic [15:0] EEPC_IDX_ARR_FIRST = 16'hB600;
  localparam logic [15:0] EEPC_IDX_ARR_LAST = 16'hB7FF;
  localparam int EEPC_ARR_BYTES = 512;
  localparam int EEPC_AXI_AW = 18;

  localparam logic [7:0] EEPC_PROG_RST = 8'h00;
  localparam logic [7:0] EEPC_PROG_WMASK = 8'hDF;
  localparam int EEPC_PROG_HV = 0;
  localparam int EEPC_PROG_LATCH = 1;
  localparam int EEPC_PROG_ERASE = 2;
  localparam int EEPC_PROG_ROW = 3;
  localparam int EEPC_PROG_BYTE = 4;
  localparam int EEPC_PROG_EVEN = 6;
  localparam int EEPC_PROG_ODD = 7;

  localparam logic [3:0] EEPC_CFG_ERASED = 4'hF;
  localparam int EEPC_CFG_MAP = 0;
  localparam int EEPC_CFG_ROM = 1;
  localparam int EEPC_CFG_WDOG = 2;
  localparam int EEPC_CFG_SEC = 3;

  localparam logic [7:0] EEPC_CTRL_RST = 8'h00;
  localparam int EEPC_CTRL_PUMP = 0;

  localparam int EEPC_STAT_TIME_OK = 2;
  localparam int EEPC_STAT_SHORT = 3;
  localparam int EEPC_STAT_SPECIAL = 4;
  localparam int EEPC_STAT_CAP_CFG = 5;

  localparam int EEPC_HV_MIN_TIME_US = 10000;
  localparam int EEPC_CLK_PERIOD_NS = 8;
  localparam int EEPC_HV_MIN_CYC =
    (EEPC_HV_MIN_TIME_US * 1000 + EEPC_CLK_PERIOD_NS - 1) / EEPC_CLK_PERIOD_NS;
  localparam int EEPC_HV_CNT_W = 21;

  localparam logic [1:0] EEPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] EEPC_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    EEPC_IDLE = 2'h0,
    EEPC_LATCHED = 2'h1,
    EEPC_HV_ON = 2'h3
  } eepc_state_e;
endpackage : eepc_pkg

/* design/eepc_req_if.sv */
`timescale 1ns/1ns
interface eepc_req_if;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic err;
  modport bus (output wr, output rd, output idx, output wdata, input rdata, input err);
  modport regs (input wr, input rd, input idx, input wdata, output rdata, output err);
endinterface : eepc_req_if

/* design/eepc_axil_slave.sv */
`timescale 1ns/1ns
module eepc_axil_slave
  import eepc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [EEPC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [EEPC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  eepc_req_if.bus req
);
  logic aw_hold_r;
  logic w_hold_r;
  logic ar_hold_r;
  logic wen_r;
  logic [15:0] aw_idx_r;
  logic [15:0] ar_idx_r;
  logic [7:0] wd_r;
  logic do_wr;
  logic do_rd;

  // write wins a shared cycle; the read just waits one more cycle
  assign do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign do_rd = ar_hold_r & ~s_axi_rvalid & ~do_wr;
  assign req.wr = do_wr & wen_r;
  assign req.rd = do_rd;
  assign req.idx = do_wr ? aw_idx_r : ar_idx_r;
  assign req.wdata = wd_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      wen_r <= 1'b0;
      aw_idx_r <= 16'h0000;
      wd_r <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= EEPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[17:2];
        s_axi_awready <= 1'b0;
      end else if (!s_axi_awready && !aw_hold_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wd_r <= s_axi_wdata[7:0];
        wen_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (!s_axi_wready && !w_hold_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= req.err ? EEPC_RESP_DECERR : EEPC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ar_hold_r <= 1'b0;
      ar_idx_r <= 16'h0000;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= EEPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_hold_r <= 1'b1;
        ar_idx_r <= s_axi_araddr[17:2];
        s_axi_arready <= 1'b0;
      end else if (!s_axi_arready && !ar_hold_r && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (do_rd) begin
        ar_hold_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, req.rdata};
        s_axi_rresp <= req.err ? EEPC_RESP_DECERR : EEPC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : eepc_axil_slave

/* design/eepc_nv_ctrl.sv */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module eepc_nv_ctrl
  import eepc_pkg::*;
#(
  parameter int HV_MIN_CYCLES = EEPC_HV_MIN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic special_mode,
  input wire logic [EEPC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [EEPC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic hv_enable,
  output logic pump_clock_select,
  output logic array_map_enable,
  output logic rom_map_enable,
  output logic security_off,
  output logic watchdog_disable
);
  eepc_req_if req ();

  eepc_axil_slave u_slave (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req.bus)
  );

  logic [7:0] mem_r [EEPC_ARR_BYTES];
  logic [3:0] cfg_cell_r;
  logic [3:0] cfg_shadow_r;
  logic load_pend_r;
  logic [7:0] prog_r;
  logic [7:0] ctrl_r;
  logic short_r;
  logic hv_enable_r;
  logic spec_meta_r;
  logic spec_sync_r;
  eepc_state_e state_r;
  eepc_state_e state_nxt;
  logic [EEPC_HV_CNT_W-1:0] hv_cnt_r;
  logic [8:0] cap_off_r;
  logic [7:0] cap_data_r;
  logic cap_cfg_r;

  logic arr_hit;
  logic hit_prog;
  logic hit_setup;
  logic hit_ctrl;
  logic hit_stat;
  logic map_en;
  logic [8:0] arr_off;
  logic prog_wr;
  logic hv_drop;
  logic time_ok;
  logic cap_ok;
  logic commit_now;
  logic par_ok;

  assign arr_hit = (req.idx >= EEPC_IDX_ARR_FIRST) && (req.idx <= EEPC_IDX_ARR_LAST);
  assign arr_off = 9'(req.idx - EEPC_IDX_ARR_FIRST);
  assign hit_prog = req.idx == EEPC_IDX_PROG;
  assign hit_setup = req.idx == EEPC_IDX_SETUP;
  assign hit_ctrl = req.idx == EEPC_IDX_CTRL;
  assign hit_stat = req.idx == EEPC_IDX_STAT;
  assign map_en = cfg_shadow_r[EEPC_CFG_MAP];

  assign prog_wr = req.wr && hit_prog;
  // voltage goes away on any PROG write that does not keep latch and voltage both set
  assign hv_drop = prog_wr && !(req.wdata[EEPC_PROG_HV] && req.wdata[EEPC_PROG_LATCH]);
  assign time_ok = hv_cnt_r >= EEPC_HV_CNT_W'(HV_MIN_CYCLES);
  assign cap_ok = req.wr && prog_r[EEPC_PROG_LATCH] && !prog_r[EEPC_PROG_HV] &&
                  (state_r != EEPC_HV_ON) &&
                  ((arr_hit && map_en) || (hit_setup && spec_sync_r));
  // commit when voltage removed after enough time
  assign commit_now = (state_r == EEPC_HV_ON) && hv_drop && time_ok;

  // odd rows only when the odd test bit stands alone
  always_comb begin
    case ({prog_r[EEPC_PROG_ODD], prog_r[EEPC_PROG_EVEN]})
      2'h2: par_ok = cap_off_r[4];
      2'h1: par_ok = !cap_off_r[4];
      default: par_ok = 1'b1;
    endcase
  end

  always_comb begin
    req.err = 1'b0;
    req.rdata = 8'h00;
    if (hit_prog) begin
      req.rdata = prog_r;
    end else if (hit_setup) begin
      // reads show the shadow loaded at reset
      req.rdata = {4'h0, cfg_shadow_r};
    end else if (hit_ctrl) begin
      req.rdata = ctrl_r;
    end else if (hit_stat) begin
      req.rdata = {2'h0, cap_cfg_r, spec_sync_r, short_r, time_ok, state_r};
    end else if (arr_hit && map_en) begin
      // paths busy with capture while latched
      req.rdata = prog_r[EEPC_PROG_LATCH] ? 8'h00 : mem_r[arr_off];
    end else begin
      req.err = 1'b1;
    end
  end

  // pin is asynchronous to clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spec_meta_r <= 1'b0;
      spec_sync_r <= 1'b0;
    end else begin
      spec_meta_r <= special_mode;
      spec_sync_r <= spec_meta_r;
    end
  end

  // setup shadow reloaded one cycle after each reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_pend_r <= 1'b1;
      cfg_shadow_r <= EEPC_CFG_ERASED;
    end else if (load_pend_r) begin
      load_pend_r <= 1'b0;
      cfg_shadow_r <= cfg_cell_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_r <= EEPC_PROG_RST;
    end else if (prog_wr) begin
      prog_r <= req.wdata & EEPC_PROG_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= EEPC_CTRL_RST;
    end else if (req.wr && hit_ctrl) begin
      ctrl_r <= {7'h00, req.wdata[EEPC_CTRL_PUMP]};
    end
  end

  // too-short pulse flag; a new event beats a write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      short_r <= 1'b0;
    end else if ((state_r == EEPC_HV_ON) && hv_drop && !time_ok) begin
      short_r <= 1'b1;
    end else if (req.wr && hit_stat && req.wdata[EEPC_STAT_SHORT]) begin
      short_r <= 1'b0;
    end
  end

  // voltage follows latch and voltage bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hv_enable_r <= 1'b0;
    end else begin
      hv_enable_r <= prog_r[EEPC_PROG_HV] && prog_r[EEPC_PROG_LATCH];
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EEPC_IDLE: begin
        if (cap_ok) begin
          state_nxt = EEPC_LATCHED;
        end
      end
      EEPC_LATCHED: begin
        if (prog_wr && !req.wdata[EEPC_PROG_LATCH]) begin
          state_nxt = EEPC_IDLE;
        end else if (prog_wr && req.wdata[EEPC_PROG_HV]) begin
          state_nxt = EEPC_HV_ON;
        end
      end
      EEPC_HV_ON: begin
        if (hv_drop) begin
          state_nxt = req.wdata[EEPC_PROG_LATCH] ? EEPC_LATCHED : EEPC_IDLE;
        end
      end
      default: state_nxt = EEPC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= EEPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // saturating voltage-on timer, restarts on each entry
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hv_cnt_r <= '0;
    end else if (state_r != EEPC_HV_ON) begin
      hv_cnt_r <= '0;
    end else if (!time_ok) begin
      hv_cnt_r <= hv_cnt_r + 1'b1;
    end
  end

  // captured address picks the byte or row; bulk erase ignores it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_off_r <= 9'h000;
      cap_data_r <= 8'h00;
      cap_cfg_r <= 1'b0;
    end else if (cap_ok) begin
      cap_off_r <= arr_off;
      cap_data_r <= req.wdata;
      // setup captured only in special mode
      cap_cfg_r <= hit_setup;
    end
  end

  // cells keep their contents over rstn; only power-on clears them
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < EEPC_ARR_BYTES; i++) begin
        mem_r[i] <= 8'hFF;
      end
      cfg_cell_r <= EEPC_CFG_ERASED;
    end else if (commit_now) begin
      if (cap_cfg_r) begin
        cfg_cell_r <= prog_r[EEPC_PROG_ERASE] ? EEPC_CFG_ERASED :
                      (cfg_cell_r & cap_data_r[3:0]);
      end else begin
        for (int i = 0; i < EEPC_ARR_BYTES; i++) begin
          // erase bit selects erase over program
          if (prog_r[EEPC_PROG_ERASE]) begin
            // byte overrides row; neither means bulk
            if (prog_r[EEPC_PROG_BYTE] ? (9'(i) == cap_off_r) :
                prog_r[EEPC_PROG_ROW] ? (9'(i) >> 4 == cap_off_r >> 4) : 1'b1) begin
              mem_r[i] <= 8'hFF;
            end
          end else if ((9'(i) == cap_off_r) && par_ok) begin
            // programming can only clear bits
            mem_r[i] <= mem_r[i] & cap_data_r;
          end
        end
      end
    end
  end

  assign hv_enable = hv_enable_r;
  // pump clock choice left to software
  assign pump_clock_select = ctrl_r[EEPC_CTRL_PUMP];
  assign array_map_enable = cfg_shadow_r[EEPC_CFG_MAP];
  assign rom_map_enable = cfg_shadow_r[EEPC_CFG_ROM];
  assign security_off = cfg_shadow_r[EEPC_CFG_SEC];
  // one blocks the watchdog timeout reset
  assign watchdog_disable = cfg_shadow_r[EEPC_CFG_WDOG];

  a_hv_follows_bits: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(prog_r[EEPC_PROG_HV] && prog_r[EEPC_PROG_LATCH]) |=> hv_enable_r ##1 hv_enable_r
      or ##1 !prog_r[EEPC_PROG_HV])
    else $error("voltage did not follow control bits");

  a_unmapped_array: assert property (
    @(posedge clk) disable iff (!rstn)
    (req.rd && arr_hit && !cfg_shadow_r[EEPC_CFG_MAP]) |-> req.err)
    else $error("array answered while removed from map");

  a_shadow_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    !load_pend_r |=> $stable(cfg_shadow_r))
    else $error("setup read value changed before reset");

  a_shadow_loads: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(load_pend_r) |-> cfg_shadow_r == $past(cfg_cell_r))
    else $error("setup shadow not loaded from cells");

  a_cfg_special_only: assert property (
    @(posedge clk) disable iff (!rstn)
    (req.wr && hit_setup && !spec_sync_r)
      |=> $stable(cap_cfg_r) && $stable(cap_off_r) && $stable(cap_data_r))
    else $error("setup capture outside special mode");

  a_latch_no_change: assert property (
    @(posedge clk) disable iff (!rstn || !por_n)
    (state_r != EEPC_HV_ON) |=> $stable(cfg_cell_r) &&
      (mem_r[$past(cap_off_r)] == $past(mem_r[cap_off_r])))
    else $error("cells changed without high voltage");

  a_byte_erase: assert property (
    @(posedge clk) disable iff (!rstn || !por_n)
    (commit_now && !cap_cfg_r && prog_r[EEPC_PROG_ERASE] && prog_r[EEPC_PROG_BYTE])
      |=> mem_r[cap_off_r] == 8'hFF)
    else $error("byte erase left data");

  a_short_no_commit: assert property (
    @(posedge clk) disable iff (!rstn || !por_n)
    ((state_r == EEPC_HV_ON) && hv_drop && (hv_cnt_r < EEPC_HV_CNT_W'(HV_MIN_CYCLES)))
      |=> short_r && $stable(cfg_cell_r) && $stable(mem_r[cap_off_r]))
    else $error("short pulse committed or not flagged");

  a_odd_rows_only: assert property (
    @(posedge clk) disable iff (!rstn || !por_n)
    (commit_now && !cap_cfg_r && !prog_r[EEPC_PROG_ERASE] && prog_r[EEPC_PROG_ODD] &&
     !prog_r[EEPC_PROG_EVEN] && !cap_off_r[4]) |=> $stable(mem_r[cap_off_r]))
    else $error("even row programmed in odd test mode");

  a_wdog_at_reset: assert property (
    @(posedge clk) disable iff (!rstn)
    $changed(watchdog_disable) |-> $past(load_pend_r))
    else $error("watchdog disable changed outside reset load");
endmodule : eepc_nv_ctrl

/* test/eeprom_program_control_tb_top.sv */
`timescale 1ns/1ns
module eeprom_program_control_tb_top;
  import eepc_pkg::*;
  localparam int HV = 20;
  localparam int W = HV + 4;
  localparam logic [1:0] OK = EEPC_RESP_OKAY;
  localparam logic [1:0] DE = EEPC_RESP_DECERR;
  logic clk, rstn, por_n, special_mode;
  logic [EEPC_AXI_AW-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic hv, pump, map_en, rom_en, sec_off, wdog_dis;
  int failures, compares;

  eepc_nv_ctrl #(.HV_MIN_CYCLES(HV)) u_dut (
    .clk(clk), .rstn(rstn), .por_n(por_n), .special_mode(special_mode),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hv_enable(hv), .pump_clock_select(pump), .array_map_enable(map_en),
    .rom_map_enable(rom_en), .security_off(sec_off), .watchdog_disable(wdog_dis)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // entered just after a rising edge; leaves one idle edge so strobes never double up
  task wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
    if (n >= 200) failures++;
    @(posedge clk);
  endtask : wr

  task rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    chk(rdata, {24'h0, ed}, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    if (n >= 200) failures++;
    @(posedge clk);
  endtask : rd

  // latch, capture, voltage for wt cycles, voltage off, release
  task op(input logic [15:0] idx, input logic [7:0] d, input logic [7:0] mode, input int wt);
    wr(EEPC_IDX_PROG, mode | 8'h02, OK);
    wr(idx, d, OK);
    wr(EEPC_IDX_PROG, mode | 8'h03, OK);
    chk(hv, 1'b1, "voltage on");
    repeat (wt) @(posedge clk);
    wr(EEPC_IDX_PROG, mode | 8'h02, OK);
    chk(hv, 1'b0, "voltage off");
    wr(EEPC_IDX_PROG, 8'h00, OK);
  endtask : op

  // system reset only; nonvolatile cells keep their contents
  task rst_pulse;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst_pulse

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    compares = 0;
    rstn = 1'b0;
    por_n = 1'b0;
    special_mode = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (20) @(posedge clk);
    por_n <= 1'b1;
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(EEPC_IDX_PROG, EEPC_PROG_RST, OK);
    rd(EEPC_IDX_SETUP, 8'h0F, OK);
    chk(map_en, 1'b1, "map after erase state");
    rd(EEPC_IDX_ARR_FIRST, 8'hFF, OK);
    rd(EEPC_IDX_ARR_LAST, 8'hFF, OK);
    rd(16'hB5FF, 8'h00, DE);
    rd(16'hB800, 8'h00, DE);
    wr(16'h1042, 8'h01, DE);
    wr(EEPC_IDX_PROG, 8'h20, OK);
    rd(EEPC_IDX_PROG, 8'h00, OK);
    $display("test reset_map done");
    wr(EEPC_IDX_PROG, 8'h02, OK);
    wr(16'hB600, 8'hA5, OK);
    rd(16'hB600, 8'h00, OK);
    chk(hv, 1'b0, "no voltage while only latched");
    wr(EEPC_IDX_PROG, 8'h00, OK);
    rd(16'hB600, 8'hFF, OK);
    op(16'hB600, 8'hA5, 8'h00, W);
    rd(16'hB600, 8'hA5, OK);
    op(16'hB600, 8'h0F, 8'h00, W);
    rd(16'hB600, 8'h05, OK);
    // voltage removed before the minimum time: cell must stay erased
    op(16'hB601, 8'h00, 8'h00, 2);
    rd(16'hB601, 8'hFF, OK);
    // short flag is sticky until a written one clears it
    rd(EEPC_IDX_STAT, 8'h08, OK);
    wr(EEPC_IDX_STAT, 8'h08, OK);
    rd(EEPC_IDX_STAT, 8'h00, OK);
    $display("test program done");
    op(16'hB612, 8'h00, 8'h00, W);
    op(16'hB613, 8'h00, 8'h00, W);
    op(16'hB620, 8'h00, 8'h00, W);
    // byte bit with row bit also set still erases one byte
    op(16'hB612, 8'h55, 8'h1C, W);
    rd(16'hB612, 8'hFF, OK);
    rd(16'hB613, 8'h00, OK);
    op(16'hB61F, 8'h55, 8'h0C, W);
    rd(16'hB613, 8'hFF, OK);
    rd(16'hB620, 8'h00, OK);
    op(16'hB7FF, 8'h55, 8'h04, W);
    rd(16'hB620, 8'hFF, OK);
    rd(16'hB600, 8'hFF, OK);
    $display("test erase done");
    op(16'hB600, 8'h00, 8'h80, W);
    rd(16'hB600, 8'hFF, OK);
    op(16'hB610, 8'h00, 8'h80, W);
    rd(16'hB610, 8'h00, OK);
    op(16'hB630, 8'h00, 8'h40, W);
    rd(16'hB630, 8'hFF, OK);
    op(16'hB620, 8'h00, 8'h40, W);
    rd(16'hB620, 8'h00, OK);
    $display("test row_parity done");
    op(EEPC_IDX_SETUP, 8'h0A, 8'h00, W);
    rst_pulse();
    rd(EEPC_IDX_SETUP, 8'h0F, OK);
    special_mode <= 1'b1;
    repeat (4) @(posedge clk);
    rd(EEPC_IDX_STAT, 8'h10, OK);
    op(EEPC_IDX_SETUP, 8'h0A, 8'h00, W);
    rd(EEPC_IDX_SETUP, 8'h0F, OK);
    chk(map_en, 1'b1, "map before reset");
    rst_pulse();
    rd(EEPC_IDX_SETUP, 8'h0A, OK);
    chk(map_en, 1'b0, "map reloaded");
    chk(wdog_dis, 1'b0, "watchdog allowed");
    chk({rom_en, sec_off}, 2'b11, "other setup bits");
    rd(16'hB620, 8'h00, DE);
    op(EEPC_IDX_SETUP, 8'h00, 8'h04, W);
    rst_pulse();
    rd(EEPC_IDX_SETUP, 8'h0F, OK);
    chk(map_en, 1'b1, "map restored");
    chk(wdog_dis, 1'b1, "watchdog prevented");
    rd(16'hB620, 8'h00, OK);
    $display("test setup_byte done");
    wr(EEPC_IDX_CTRL, 8'h01, OK);
    chk(pump, 1'b1, "pump clock on");
    rd(EEPC_IDX_CTRL, 8'h01, OK);
    wr(EEPC_IDX_CTRL, 8'h00, OK);
    chk(pump, 1'b0, "pump clock off");
    // byte lane 0 off: answered, but nothing is written
    wstrb <= 4'h0;
    wr(EEPC_IDX_CTRL, 8'h01, OK);
    wstrb <= 4'hF;
    chk(pump, 1'b0, "masked write ignored");
    $display("test pump_clock done");
    complete_run();
  end
endmodule : eeprom_program_control_tb_top
